/* src/rpl_core.sv */
// Read parameters, serial/four-line mode switch and per-sector lock command handling
`timescale 1ns/1ps
`include "rpl_regs.svh"
module rpl_core #(
  parameter int SECTOR_BITS = `RPL_SECTOR_BITS,
  parameter logic [3:0] SERIAL_DUMMY = `RPL_SERIAL_DUMMY
) (
  // Clocks and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic link_sclk_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Status bits from the rest of the device
  input wire logic quad_io_enable_i,
  input wire logic write_enable_latch_i,
  input wire logic lock_scheme_select_i,
  input wire logic protect_complement_i,
  input wire logic protect_small_unit_i,
  input wire logic protect_from_bottom_i,
  input wire logic [2:0] protect_range_bits_i,
  // Wrap setting from the serial wrap command, and reset command
  input wire logic spi_wrap_load_i,
  input wire logic [1:0] spi_wrap_size_bits_i,
  input wire logic reset_cmd_i,
  // Protection query from program and erase logic
  input wire logic chk_req_i,
  input wire rpl_pkg::rpl_chk_kind_t chk_kind_i,
  input wire logic [23:0] chk_addr_i,
  output logic chk_done_o,
  output logic chk_refused_o,
  // Read settings and command events
  output logic four_line_command_mode_o,
  output logic [3:0] dummy_clocks_o,
  output logic [6:0] wrap_bytes_o,
  output logic cmd_done_o,
  output logic cmd_ignored_o
);

  localparam int NUM_SECTORS = 1 << SECTOR_BITS;
  localparam int SEC_HI = `RPL_SECTOR_LSB + SECTOR_BITS - 1;

  // ****************************************
  // Core state
  // ****************************************
  rpl_pkg::rpl_mode_t mode_reg;
  logic [1:0] dummy_code_reg;
  logic [1:0] wrap_code_reg;
  logic lock_reg [NUM_SECTORS];
  logic cs_sync;
  logic cs_prev_reg;
  logic tog_seen_reg;

  // ****************************************
  // Link domain state
  // ****************************************
  logic in_frame_reg;
  logic tog_reg;
  logic [6:0] nbits_reg;
  logic [31:0] sh_reg;
  logic [7:0] op_reg;
  logic [SECTOR_BITS-1:0] link_sector_reg;

  logic four_link;
  logic [7:0] nbits_sum;
  logic [6:0] nbits_next;
  logic [31:0] sh_next;
  logic [7:0] lock_byte;

  // ****************************************
  // Link side: command capture on rising edges
  // ****************************************
  // Mode only changes between frames, so it is stable while the link clock runs
  assign four_link = (mode_reg == rpl_pkg::RPL_MODE_FOUR);

  always_comb begin
    if (four_link) begin
      nbits_sum = {1'b0, nbits_reg} + 8'h04;
      sh_next = {sh_reg[27:0], io_i};
    end else begin
      nbits_sum = {1'b0, nbits_reg} + 8'h01;
      sh_next = {sh_reg[30:0], io_i[0]};
    end
    if (!in_frame_reg) begin
      nbits_next = four_link ? 7'h04 : 7'h01;
    end else if (nbits_sum[7]) begin
      nbits_next = `RPL_LEN_MAX;
    end else begin
      nbits_next = nbits_sum[6:0];
    end
  end

  // Frame flag ends with chip select, not with a clock edge
  always_ff @(posedge link_sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  always_ff @(posedge link_sclk_i) begin
    nbits_reg <= nbits_next;
    sh_reg <= sh_next;
  end

  // Toggle per frame lets the core skip frames that carried no clock edges
  // Core reset clears it too; the link clock is stopped then, so release is safe
  always_ff @(posedge link_sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_reg <= 1'b0;
    end else if (!in_frame_reg) begin
      tog_reg <= ~tog_reg;
    end
  end

  always_ff @(posedge link_sclk_i) begin
    if (nbits_next == `RPL_LEN_OP) begin
      op_reg <= sh_next[7:0];
    end
    if (nbits_next == `RPL_LEN_ADDR) begin
      link_sector_reg <= sh_next[SEC_HI:`RPL_SECTOR_LSB];
    end
  end

  // ****************************************
  // Link side: lock byte out on falling edges
  // ****************************************
  // Lock bits change only between frames, so the lookup is stable here
  assign lock_byte = {7'h00, lock_reg[link_sector_reg]};

  always_ff @(negedge link_sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end else if (op_reg == `RPL_OP_READ_LOCK && nbits_reg >= `RPL_LEN_ADDR && in_frame_reg) begin
      if (four_link) begin
        io_o <= nbits_reg[2] ? lock_byte[3:0] : lock_byte[7:4];
        io_oe_o <= 4'hf;
      end else begin
        io_o <= {2'b00, lock_byte[~nbits_reg[2:0]], 1'b0};
        io_oe_o <= 4'h2;
      end
    end else begin
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end
  end

  // ****************************************
  // Frame end detection in the core domain
  // ****************************************
  rpl_sync2 #(
    .RST_VAL(1'b1)
  ) u_cs_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(cs_n_i),
    .q_o(cs_sync)
  );

  logic cs_rise;
  logic frame_end;

  assign cs_rise = cs_sync & ~cs_prev_reg;
  assign frame_end = cs_rise && (tog_reg != tog_seen_reg);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cs_prev_reg <= 1'b1;
      tog_seen_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_sync;
      if (cs_rise) begin
        tog_seen_reg <= tog_reg;
      end
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  logic exec_enter;
  logic exec_exit;
  logic exec_param;
  logic exec_lock;
  logic exec_unlock;
  logic exec_lock_all;
  logic ignore_cmd;

  // Captured words are read only after the link clock has stopped
  always_comb begin
    exec_enter = 1'b0;
    exec_exit = 1'b0;
    exec_param = 1'b0;
    exec_lock = 1'b0;
    exec_unlock = 1'b0;
    exec_lock_all = 1'b0;
    ignore_cmd = 1'b0;
    if (frame_end && nbits_reg >= `RPL_LEN_OP) begin
      if (mode_reg == rpl_pkg::RPL_MODE_SERIAL) begin
        if (op_reg == `RPL_OP_ENTER_FOUR && nbits_reg == `RPL_LEN_OP) begin
          exec_enter = quad_io_enable_i;
          ignore_cmd = ~quad_io_enable_i;
        end else if (op_reg == `RPL_OP_SET_PARAM) begin
          ignore_cmd = 1'b1;
        end
      end else begin
        if (op_reg == `RPL_OP_EXIT_FOUR && nbits_reg == `RPL_LEN_OP) begin
          exec_exit = 1'b1;
        end else if (op_reg == `RPL_OP_SET_PARAM && nbits_reg == `RPL_LEN_PARAM) begin
          exec_param = 1'b1;
        end
      end
      if (op_reg == `RPL_OP_LOCK && nbits_reg == `RPL_LEN_ADDR) begin
        exec_lock = write_enable_latch_i;
        ignore_cmd = ~write_enable_latch_i;
      end else if (op_reg == `RPL_OP_UNLOCK && nbits_reg == `RPL_LEN_ADDR) begin
        exec_unlock = write_enable_latch_i;
        ignore_cmd = ~write_enable_latch_i;
      end else if (op_reg == `RPL_OP_LOCK_ALL && nbits_reg == `RPL_LEN_OP) begin
        exec_lock_all = write_enable_latch_i;
        ignore_cmd = ~write_enable_latch_i;
      end
    end
  end

  // ****************************************
  // Mode register
  // ****************************************
  // Only the mode flips here; wrap code and outside latches are untouched
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || reset_cmd_i) begin
      mode_reg <= rpl_pkg::RPL_MODE_SERIAL;
    end else if (exec_enter) begin
      mode_reg <= rpl_pkg::RPL_MODE_FOUR;
    end else if (exec_exit) begin
      mode_reg <= rpl_pkg::RPL_MODE_SERIAL;
    end
  end

  // ****************************************
  // Read parameters
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || reset_cmd_i) begin
      dummy_code_reg <= `RPL_DUMMY_CODE_RST;
    end else if (exec_param) begin
      dummy_code_reg <= sh_reg[`RPL_DUMMY_MSB:`RPL_DUMMY_LSB];
    end
  end

  // Serial wrap loads only arrive in serial mode, never with a C0h
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || reset_cmd_i) begin
      wrap_code_reg <= `RPL_WRAP_CODE_RST;
    end else if (exec_param) begin
      wrap_code_reg <= sh_reg[`RPL_WRAP_MSB:`RPL_WRAP_LSB];
    end else if (spi_wrap_load_i && mode_reg == rpl_pkg::RPL_MODE_SERIAL) begin
      wrap_code_reg <= spi_wrap_size_bits_i;
    end
  end

  // Outputs trail the state by one cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      four_line_command_mode_o <= 1'b0;
      dummy_clocks_o <= SERIAL_DUMMY;
      wrap_bytes_o <= `RPL_MIN_WRAP;
    end else begin
      four_line_command_mode_o <= (mode_reg == rpl_pkg::RPL_MODE_FOUR);
      if (mode_reg == rpl_pkg::RPL_MODE_FOUR) begin
        dummy_clocks_o <= ({2'b00, dummy_code_reg} + 4'h1) << 1;
      end else begin
        dummy_clocks_o <= SERIAL_DUMMY;
      end
      wrap_bytes_o <= `RPL_MIN_WRAP << wrap_code_reg;
    end
  end

  // ****************************************
  // Sector lock bits
  // ****************************************
  logic [SECTOR_BITS-1:0] frame_sector;

  assign frame_sector = link_sector_reg;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || reset_cmd_i || exec_lock_all) begin
      for (int i = 0; i < NUM_SECTORS; i++) begin
        lock_reg[i] <= 1'b1;
      end
    end else if (exec_lock) begin
      lock_reg[frame_sector] <= 1'b1;
    end else if (exec_unlock) begin
      lock_reg[frame_sector] <= 1'b0;
    end
  end

  // ****************************************
  // Protection query
  // ****************************************
  logic [SECTOR_BITS-1:0] chk_sector;
  logic any32;
  logic any64;
  logic legacy_hit;
  logic refused;

  assign chk_sector = chk_addr_i[SEC_HI:`RPL_SECTOR_LSB];

  always_comb begin
    any32 = 1'b0;
    any64 = 1'b0;
    for (int i = 0; i < (1 << `RPL_SEC_32K_LOG); i++) begin
      any32 = any32 | lock_reg[{chk_sector[SECTOR_BITS-1:`RPL_SEC_32K_LOG], `RPL_SEC_32K_LOG'(i)}];
    end
    for (int i = 0; i < (1 << `RPL_SEC_64K_LOG); i++) begin
      any64 = any64 | lock_reg[{chk_sector[SECTOR_BITS-1:`RPL_SEC_64K_LOG], `RPL_SEC_64K_LOG'(i)}];
    end
  end

  rpl_legacy_protect #(
    .SECTOR_BITS(SECTOR_BITS)
  ) u_legacy (
    .sector_i(chk_sector),
    .complement_i(protect_complement_i),
    .small_unit_i(protect_small_unit_i),
    .from_bottom_i(protect_from_bottom_i),
    .range_bits_i(protect_range_bits_i),
    .hit_o(legacy_hit)
  );

  always_comb begin
    refused = legacy_hit;
    if (lock_scheme_select_i) begin
      case (chk_kind_i)
        rpl_pkg::RPL_CHK_ERASE_32K: begin
          refused = any32;
        end
        rpl_pkg::RPL_CHK_ERASE_64K: begin
          refused = any64;
        end
        default: begin
          refused = lock_reg[chk_sector];
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      chk_done_o <= 1'b0;
      chk_refused_o <= 1'b0;
    end else begin
      chk_done_o <= chk_req_i;
      if (chk_req_i) begin
        chk_refused_o <= refused;
      end
    end
  end

  // ****************************************
  // Command events
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmd_done_o <= 1'b0;
      cmd_ignored_o <= 1'b0;
    end else begin
      cmd_done_o <= exec_enter | exec_exit | exec_param | exec_lock | exec_unlock | exec_lock_all;
      cmd_ignored_o <= ignore_cmd;
    end
  end

endmodule // rpl_core

/* src/rpl_regs.svh */
// Opcodes, field positions, reset values and geometry of the parameter, mode and lock block
`ifndef RPL_REGS_SVH
`define RPL_REGS_SVH

// ****************************************
// Opcodes
// ****************************************
`define RPL_OP_SET_PARAM 8'hc0
`define RPL_OP_ENTER_FOUR 8'h38
`define RPL_OP_EXIT_FOUR 8'hff
`define RPL_OP_LOCK 8'h36
`define RPL_OP_UNLOCK 8'h39
`define RPL_OP_READ_LOCK 8'h3d
`define RPL_OP_LOCK_ALL 8'h7e

// ****************************************
// Frame lengths in bits
// ****************************************
`define RPL_LEN_OP 7'h08
`define RPL_LEN_PARAM 7'h10
`define RPL_LEN_ADDR 7'h20
`define RPL_LEN_MAX 7'h7f

// ****************************************
// Parameter byte fields
// ****************************************
`define RPL_DUMMY_MSB 5
`define RPL_DUMMY_LSB 4
`define RPL_WRAP_MSB 1
`define RPL_WRAP_LSB 0

// ****************************************
// Reset values and read settings
// ****************************************
`define RPL_DUMMY_CODE_RST 2'h0
`define RPL_WRAP_CODE_RST 2'h0
`define RPL_SERIAL_DUMMY 4'h8
`define RPL_MIN_WRAP 7'h08

// ****************************************
// Sector geometry
// ****************************************
`define RPL_SECTOR_LSB 12
`define RPL_SECTOR_BITS 12
`define RPL_SEC_32K_LOG 3
`define RPL_SEC_64K_LOG 4
`define RPL_SMALL_CAP_CODE 3'h4
`define RPL_BLOCK_SECTORS 16

`endif

/* src/rpl_pkg.sv */
// Types shared by the parameter, mode and lock block
package rpl_pkg;

  typedef enum logic [1:0] {
    RPL_CHK_PROGRAM = 2'b00,
    RPL_CHK_ERASE_4K = 2'b01,
    RPL_CHK_ERASE_32K = 2'b10,
    RPL_CHK_ERASE_64K = 2'b11
  } rpl_chk_kind_t;

  typedef enum logic {
    RPL_MODE_SERIAL = 1'b0,
    RPL_MODE_FOUR = 1'b1
  } rpl_mode_t;

endpackage

/* src/rpl_sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
module rpl_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Level
  input wire logic d_i,
  output logic q_o
);

  logic meta_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule // rpl_sync2

/* src/rpl_legacy_protect.sv */
// Range protection decode used when per-sector locking is off
`timescale 1ns/1ps
`include "rpl_regs.svh"
module rpl_legacy_protect #(
  parameter int SECTOR_BITS = `RPL_SECTOR_BITS
) (
  // Sector under test
  input wire logic [SECTOR_BITS-1:0] sector_i,
  // Range settings
  input wire logic complement_i,
  input wire logic small_unit_i,
  input wire logic from_bottom_i,
  input wire logic [2:0] range_bits_i,
  // Result
  output logic hit_o
);

  localparam logic [SECTOR_BITS:0] ALL_SPAN = (SECTOR_BITS+1)'(1 << SECTOR_BITS);
  localparam logic [SECTOR_BITS:0] ONE = (SECTOR_BITS+1)'(1);
  localparam logic [SECTOR_BITS:0] BLOCK = (SECTOR_BITS+1)'(`RPL_BLOCK_SECTORS);

  logic [SECTOR_BITS:0] span;
  logic in_range;

  always_comb begin
    span = '0;
    if (range_bits_i == 3'h7) begin
      span = ALL_SPAN;
    end else if (range_bits_i != 3'h0) begin
      if (small_unit_i) begin
        // Small units stop growing at one 32kB half block
        if (range_bits_i >= `RPL_SMALL_CAP_CODE) begin
          span = ONE << (`RPL_SMALL_CAP_CODE - 3'h1);
        end else begin
          span = ONE << (range_bits_i - 3'h1);
        end
      end else begin
        span = BLOCK << (range_bits_i - 3'h1);
      end
    end
    if (from_bottom_i) begin
      in_range = {1'b0, sector_i} < span;
    end else begin
      in_range = {1'b0, sector_i} >= (ALL_SPAN - span);
    end
    hit_o = in_range ^ complement_i;
  end

endmodule // rpl_legacy_protect

/* testbench/rpl_core_chk.sv */
// Checker for the parameter, mode and lock block
`timescale 1ns/1ps
module rpl_core_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic cs_n_i,
  input wire logic [3:0] io_oe_o,
  input wire logic reset_cmd_i,
  input wire logic chk_req_i,
  input wire logic chk_done_o,
  input wire logic four_line_command_mode_o,
  input wire logic [3:0] dummy_clocks_o,
  input wire logic [6:0] wrap_bytes_o,
  input wire logic cmd_done_o,
  input wire logic cmd_ignored_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_ask;
    chk_req_i;
  endsequence
  sequence s_answer;
    chk_done_o;
  endsequence
  chk_query_answer: assert property (s_ask |=> s_answer)
    else $error("query got no answer");
  chk_query_cause: assert property (chk_done_o |-> $past(chk_req_i))
    else $error("answer without query");
  chk_reset_defaults: assert property ($rose(rst_n_i) |->
    !four_line_command_mode_o && dummy_clocks_o == 4'h8 && wrap_bytes_o == 7'h08)
    else $error("bad defaults after reset");
  chk_serial_dummy: assert property (!four_line_command_mode_o |-> dummy_clocks_o == 4'h8)
    else $error("serial dummy not fixed");
  chk_four_dummy: assert property (four_line_command_mode_o |-> dummy_clocks_o inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("illegal dummy count");
  chk_wrap_codes: assert property (wrap_bytes_o inside {7'h08, 7'h10, 7'h20, 7'h40})
    else $error("illegal wrap length");
  chk_mode_framed: assert property ($changed(four_line_command_mode_o) |->
    $past(cs_n_i, 2) && $past(cs_n_i, 3))
    else $error("mode changed inside a frame");
  chk_wrap_kept: assert property ($changed(four_line_command_mode_o) &&
    !$past(reset_cmd_i, 2) && !$past(reset_cmd_i, 3) |-> $stable(wrap_bytes_o))
    else $error("wrap changed with mode");
  chk_event_excl: assert property (!(cmd_done_o && cmd_ignored_o))
    else $error("done and ignored together");
  chk_ignore_pulse: assert property (cmd_ignored_o |=> !cmd_ignored_o)
    else $error("ignored event too long");
  chk_oe_idle: assert property (cs_n_i && $past(cs_n_i) |-> io_oe_o == 4'h0)
    else $error("driving while deselected");
  chk_oe_width: assert property (io_oe_o != 4'h0 |->
    io_oe_o == (four_line_command_mode_o ? 4'hf : 4'h2))
    else $error("wrong output lanes");
endmodule // rpl_core_chk

bind rpl_core rpl_core_chk u_chk (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .cs_n_i(cs_n_i),
  .io_oe_o(io_oe_o),
  .reset_cmd_i(reset_cmd_i),
  .chk_req_i(chk_req_i),
  .chk_done_o(chk_done_o),
  .four_line_command_mode_o(four_line_command_mode_o),
  .dummy_clocks_o(dummy_clocks_o),
  .wrap_bytes_o(wrap_bytes_o),
  .cmd_done_o(cmd_done_o),
  .cmd_ignored_o(cmd_ignored_o)
);

/* testbench/rpl_host.sv */
// Host serial controller model driving select, clock and data
`timescale 1ns/1ps
module rpl_host (
  // Resolved data lines
  input wire logic [3:0] bus_i,
  // To device
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    io_o = 4'h5;
    // Deselect edge at power-up clears the device's link-side frame flag and output flops
    #1 cs_n_o = 1'b1;
  end
  // Clock stands low between frames; 64 ns per clock
  task automatic send(input logic [31:0] v, input int n, input logic four, input int rd,
                      output logic [7:0] rb);
    int step;
    step = four ? 4 : 1;
    rb = 8'h00;
    cs_n_o = 1'b0;
    #32;
    for (int i = 0; i < n; i += step) begin
      io_o = four ? v[31-i -: 4] : {~io_o[3:1], v[31-i]};
      #16 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
      #16;
    end
    io_o = ~io_o;
    for (int i = 0; i < rd; i += step) begin
      #16 rb = four ? {rb[3:0], bus_i} : {rb[6:0], bus_i[1]};
      sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
      #16;
    end
    cs_n_o = 1'b1;
    io_o = ~io_o;
    // Idle gap well past the minimum deselect time
    #400;
  endtask
endmodule // rpl_host

/* testbench/testbench.sv */
// Self-checking bench for the parameter, mode and lock block
`timescale 1ns/1ps
module testbench;
  logic core_clk_i, rst_n_i, qe, write_enable_latch, lock_scheme_select, cmp, sml, bot, wld, rcmd, req;
  logic sclk, cs_n, done, refused, mode, cdone, cign;
  logic [2:0] bp;
  logic [1:0] wcode;
  rpl_pkg::rpl_chk_kind_t kind;
  logic [23:0] qaddr;
  logic [3:0] hio, dio, doe, dummy;
  wire logic [3:0] bus;
  logic [6:0] wrap;
  logic [7:0] rb;
  int miscompares, total_checks, ign_cnt, done_cnt, n;

  assign bus = (doe & dio) | (~doe & hio);

  rpl_core dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_sclk_i(sclk), .cs_n_i(cs_n),
    .io_i(bus), .io_o(dio), .io_oe_o(doe), .quad_io_enable_i(qe), .write_enable_latch_i(write_enable_latch),
    .lock_scheme_select_i(lock_scheme_select), .protect_complement_i(cmp), .protect_small_unit_i(sml),
    .protect_from_bottom_i(bot), .protect_range_bits_i(bp), .spi_wrap_load_i(wld),
    .spi_wrap_size_bits_i(wcode), .reset_cmd_i(rcmd), .chk_req_i(req), .chk_kind_i(kind),
    .chk_addr_i(qaddr), .chk_done_o(done), .chk_refused_o(refused),
    .four_line_command_mode_o(mode), .dummy_clocks_o(dummy), .wrap_bytes_o(wrap),
    .cmd_done_o(cdone), .cmd_ignored_o(cign)
  );
  rpl_host u_host (.bus_i(bus), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(hio));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (cign === 1'b1)
      ign_cnt++;
    if (cdone === 1'b1)
      done_cnt++;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  task automatic frame(input logic [31:0] v, input int bits, input logic four);
    u_host.send(v, bits, four, 0, rb);
  endtask
  task automatic rdlock(input logic [11:0] sec, input logic four, input logic exp);
    u_host.send({8'h3d, sec, 12'h000}, 32, four, 8, rb);
    chk("lock byte", {7'h00, exp}, rb);
  endtask
  task automatic ask(input rpl_pkg::rpl_chk_kind_t k, input logic [11:0] sec, input logic exp);
    @(posedge core_clk_i);
    req <= 1'b1;
    kind <= k;
    qaddr <= {sec, 12'h000};
    @(posedge core_clk_i);
    req <= 1'b0;
    @(negedge core_clk_i);
    chk("query done", 1, done);
    chk("refused", exp, refused);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Hang guard
  // ****************************************
  initial begin
    #1ms;
    miscompares++;
    test_done;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n_i = 1'b1;
    {qe, write_enable_latch, cmp, sml, bot, wld, rcmd, req} = 8'h00;
    lock_scheme_select = 1'b1;
    bp = 3'h0;
    wcode = 2'h0;
    kind = rpl_pkg::RPL_CHK_PROGRAM;
    qaddr = 24'h000000;
    // Definite falling edge so the link-side toggle is cleared
    #1 rst_n_i = 1'b0;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk("mode", 0, mode);
    chk("dummy", 8, dummy);
    chk("wrap", 8, wrap);
    rdlock(12'h005, 1'b0, 1'b1);
    $display("defaults test ended");
    n = ign_cnt;
    frame({8'hc0, 8'h31, 16'h0000}, 16, 1'b0);
    chk("ignored count", n + 1, ign_cnt);
    chk("wrap", 8, wrap);
    @(posedge core_clk_i);
    wcode <= 2'h2;
    wld <= 1'b1;
    @(posedge core_clk_i);
    wld <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk("wrap", 32, wrap);
    frame(32'h38000000, 8, 1'b0);
    chk("mode", 0, mode);
    chk("ignored count", n + 2, ign_cnt);
    @(posedge core_clk_i);
    qe <= 1'b1;
    frame(32'h38000000, 8, 1'b0);
    chk("mode", 1, mode);
    chk("wrap", 32, wrap);
    chk("dummy", 2, dummy);
    frame(32'h38000000, 8, 1'b1);
    chk("mode", 1, mode);
    // Host sets parameters again after entering four-line mode
    for (int c = 0; c < 16; c += 5) begin
      frame({8'hc0, 2'h0, c[3:2], 2'h0, c[1:0], 16'h0000}, 16, 1'b1);
      chk("dummy", 2 + 2 * c[3:2], dummy);
      chk("wrap", 8 << c[1:0], wrap);
    end
    frame(32'hff000000, 8, 1'b1);
    chk("mode", 0, mode);
    chk("wrap", 64, wrap);
    chk("dummy", 8, dummy);
    $display("mode test ended");
    frame({8'h39, 12'h005, 12'h000}, 32, 1'b0);
    rdlock(12'h005, 1'b0, 1'b1);
    @(posedge core_clk_i);
    write_enable_latch <= 1'b1;
    frame({8'h39, 12'h005, 12'h000}, 32, 1'b0);
    rdlock(12'h005, 1'b0, 1'b0);
    ask(rpl_pkg::RPL_CHK_PROGRAM, 12'h005, 1'b0);
    ask(rpl_pkg::RPL_CHK_PROGRAM, 12'h006, 1'b1);
    ask(rpl_pkg::RPL_CHK_ERASE_4K, 12'h006, 1'b1);
    for (int s = 0; s < 8; s++)
      frame({8'h39, s[11:0], 12'h000}, 32, 1'b0);
    ask(rpl_pkg::RPL_CHK_ERASE_32K, 12'h000, 1'b0);
    ask(rpl_pkg::RPL_CHK_ERASE_64K, 12'h000, 1'b1);
    frame({8'h36, 12'h003, 12'h000}, 32, 1'b0);
    rdlock(12'h003, 1'b0, 1'b1);
    ask(rpl_pkg::RPL_CHK_ERASE_32K, 12'h000, 1'b1);
    ask(rpl_pkg::RPL_CHK_ERASE_4K, 12'h004, 1'b0);
    @(posedge core_clk_i);
    lock_scheme_select <= 1'b0;
    ask(rpl_pkg::RPL_CHK_PROGRAM, 12'h003, 1'b0);
    @(posedge core_clk_i);
    bp <= 3'h7;
    ask(rpl_pkg::RPL_CHK_PROGRAM, 12'h005, 1'b1);
    @(posedge core_clk_i);
    bp <= 3'h1;
    bot <= 1'b1;
    ask(rpl_pkg::RPL_CHK_ERASE_64K, 12'h00f, 1'b1);
    ask(rpl_pkg::RPL_CHK_PROGRAM, 12'h010, 1'b0);
    @(posedge core_clk_i);
    sml <= 1'b1;
    ask(rpl_pkg::RPL_CHK_PROGRAM, 12'h000, 1'b1);
    ask(rpl_pkg::RPL_CHK_PROGRAM, 12'h001, 1'b0);
    @(posedge core_clk_i);
    cmp <= 1'b1;
    bot <= 1'b0;
    ask(rpl_pkg::RPL_CHK_PROGRAM, 12'hfff, 1'b0);
    ask(rpl_pkg::RPL_CHK_PROGRAM, 12'h000, 1'b1);
    @(posedge core_clk_i);
    {lock_scheme_select, cmp, sml, bp} <= 6'h20;
    n = done_cnt;
    frame(32'h7e000000, 8, 1'b0);
    chk("done count", n + 1, done_cnt);
    rdlock(12'h005, 1'b0, 1'b1);
    $display("lock test ended");
    frame(32'h38000000, 8, 1'b0);
    frame({8'h39, 12'h009, 12'h000}, 32, 1'b1);
    rdlock(12'h009, 1'b1, 1'b0);
    @(posedge core_clk_i);
    wcode <= 2'h1;
    wld <= 1'b1;
    @(posedge core_clk_i);
    wld <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk("wrap", 64, wrap);
    rcmd <= 1'b1;
    @(posedge core_clk_i);
    rcmd <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk("mode", 0, mode);
    chk("wrap", 8, wrap);
    chk("dummy", 8, dummy);
    rdlock(12'h009, 1'b0, 1'b1);
    $display("reset command test ended");
    test_done;
  end
endmodule // testbench
